// >>> p3m_defs.svh
// constants for the third-port media interface: widths, unit counts, link timing
// assumes a 100 MHz system clock on both ends
`ifndef P3M_DEFS_SVH
`define P3M_DEFS_SVH

// data layout on the link
`define P3M_BYTE_W 8
`define P3M_PIN_W 4
// index of the last unit in a byte: nibbles and dibits, low unit first
`define P3M_NIB_LAST 2'h1
`define P3M_DIBIT_LAST 2'h3

// link clock made by an end's own divider
`define P3M_SYS_PERIOD_NS 10
`define P3M_LINK_PERIOD_NS 160
`define P3M_LINK_HALF (`P3M_LINK_PERIOD_NS / (2 * `P3M_SYS_PERIOD_NS))

`endif

// >>> p3m_pkg.sv
// types and mode helpers shared by both ends of the third-port media link
// assumes the mode is static while out of reset
package p3m_pkg;

  typedef enum logic [2:0] {
    P3M_MII_PHY   = 3'h0,
    P3M_MII_MAC   = 3'h1,
    P3M_RMII_NORM = 3'h2,
    P3M_RMII_CLK  = 3'h3,
    P3M_RGMII     = 3'h4
  } p3m_mode_e;

  // device drives the transmit clock pin only as an mii phy
  function automatic logic p3m_dev_drv_txc(input p3m_mode_e m);
    return m == P3M_MII_PHY;
  endfunction : p3m_dev_drv_txc

  // device drives the receive clock pin as mii phy, rmii ref source, rgmii
  function automatic logic p3m_dev_drv_rxc(input p3m_mode_e m);
    return m == P3M_MII_PHY || m == P3M_RMII_CLK || m == P3M_RGMII;
  endfunction : p3m_dev_drv_rxc

  function automatic logic p3m_prt_drv_txc(input p3m_mode_e m);
    return m == P3M_MII_MAC || m == P3M_RMII_NORM || m == P3M_RGMII;
  endfunction : p3m_prt_drv_txc

  function automatic logic p3m_prt_drv_rxc(input p3m_mode_e m);
    return m == P3M_MII_MAC;
  endfunction : p3m_prt_drv_rxc

  function automatic logic p3m_is_rmii(input p3m_mode_e m);
    return m == P3M_RMII_NORM || m == P3M_RMII_CLK;
  endfunction : p3m_is_rmii

  function automatic logic p3m_is_mii(input p3m_mode_e m);
    return m == P3M_MII_PHY || m == P3M_MII_MAC;
  endfunction : p3m_is_mii

  // append one unit at the top, low unit arrives first
  function automatic logic [7:0] p3m_shift_in(input logic [7:0] acc, input logic [3:0] u, input logic rmii);
    return rmii ? {u[1:0], acc[7:2]} : {u, acc[7:4]};
  endfunction : p3m_shift_in

  function automatic logic [7:0] p3m_shift_out(input logic [7:0] acc, input logic rmii);
    return rmii ? {2'h0, acc[7:2]} : {4'h0, acc[7:4]};
  endfunction : p3m_shift_out

  function automatic logic [3:0] p3m_unit(input logic [7:0] acc, input logic rmii);
    return rmii ? {2'h0, acc[1:0]} : acc[3:0];
  endfunction : p3m_unit

endpackage : p3m_pkg

// >>> p3m_if.sv
// pin-level link between the device end and the partner end
// assumes pull-downs on every pin: an undriven clock pin reads low
interface p3m_if;
  // two-way clock pins, per end
  logic dev_txc_o;
  logic dev_txc_oe;
  logic prt_txc_o;
  logic prt_txc_oe;
  logic dev_rxc_o;
  logic dev_rxc_oe;
  logic prt_rxc_o;
  logic prt_rxc_oe;
  logic txc;
  logic rxc;
  // partner to device
  logic tx_qual;
  logic tx_er;
  logic [3:0] txd;
  // device to partner
  logic rx_qual;
  logic rx_er;
  logic [3:0] rxd;

  // wire level from the enables, pull-down when nobody drives
  assign txc = dev_txc_oe ? dev_txc_o : (prt_txc_oe & prt_txc_o);
  assign rxc = dev_rxc_oe ? dev_rxc_o : (prt_rxc_oe & prt_rxc_o);

  modport dev (
    input txc, rxc, tx_qual, tx_er, txd,
    output dev_txc_o, dev_txc_oe, dev_rxc_o, dev_rxc_oe, rx_qual, rx_er, rxd
  );
  modport prt (
    input txc, rxc, rx_qual, rx_er, rxd,
    output prt_txc_o, prt_txc_oe, prt_rxc_o, prt_rxc_oe, tx_qual, tx_er, txd
  );
endinterface : p3m_if

// >>> p3m_dev.sv
// device end of the third-port media interface: mii phy/mac, rmii normal/clock, rgmii
// assumes a static i_mode, partner on p3m_if, link pins sampled by i_ref_clk
`include "p3m_defs.svh"

module p3m_dev #(
  parameter int BUF_DEPTH = 2,
  parameter int LINK_HALF = `P3M_LINK_HALF
) (
  // clock and reset
  input wire logic i_ref_clk,
  input wire logic i_reset,
  // static configuration
  input wire p3m_pkg::p3m_mode_e i_mode,
  // link pins
  p3m_if.dev lnk,
  // bytes taken from the partner
  output logic o_rx_valid,
  output logic [7:0] o_rx_data,
  output logic o_rx_err,
  // bytes to send to the partner
  input wire logic i_tx_valid,
  input wire logic [7:0] i_tx_data,
  input wire logic i_tx_err,
  output logic o_tx_ready
);
  import p3m_pkg::*;

  localparam int PW = (BUF_DEPTH > 1) ? $clog2(BUF_DEPTH) : 1;
  localparam int CW = $clog2(BUF_DEPTH + 1);
  localparam int DW = $clog2(LINK_HALF + 1);

  logic rmii;
  logic [7:0] s1_reg;
  logic [7:0] s2_reg;
  logic [7:0] s3_reg;
  logic txc_rise;
  logic in_rise;
  logic out_fall;
  logic [3:0] d_in;
  logic er_in;
  logic [DW-1:0] div_reg;
  logic lck_reg;
  logic txc_oe_reg;
  logic rxc_oe_reg;
  logic txc_o_reg;
  logic rxc_o_reg;
  logic [1:0] icnt_reg;
  logic [7:0] iacc_reg;
  logic ierr_reg;
  logic [8:0] mem_reg [BUF_DEPTH];
  logic [PW-1:0] wp_reg;
  logic [PW-1:0] rp_reg;
  logic [CW-1:0] cnt_reg;
  logic [CW-1:0] cnt_next;
  logic push;
  logic pop;
  logic [1:0] ocnt_reg;
  logic [7:0] osh_reg;
  logic q_reg;
  logic er_reg;
  logic [3:0] d_reg;

  assign rmii = p3m_is_rmii(i_mode);

  // pins from the other domain: two flops, then a third for edges
  always_ff @(posedge i_ref_clk or posedge i_reset) begin
    if (i_reset) begin
      s1_reg <= 8'h00;
      s2_reg <= 8'h00;
      s3_reg <= 8'h00;
    end else begin
      s1_reg <= {lnk.txc, lnk.rxc, lnk.tx_qual, lnk.tx_er, lnk.txd};
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
    end
  end

  // inbound edge: rmii normal clocks both ways from the reference in
  assign txc_rise = s2_reg[7] & ~s3_reg[7];
  assign in_rise = (i_mode == P3M_RMII_CLK) ? (s2_reg[6] & ~s3_reg[6]) : txc_rise;
  assign out_fall = (i_mode == P3M_RMII_NORM) ? (~s2_reg[7] & s3_reg[7]) : (~s2_reg[6] & s3_reg[6]);

  // upper bits masked in rmii, low pair always used
  assign d_in = {rmii ? 2'h0 : s2_reg[3:2], s2_reg[1:0]};
  // error pin only counts in mii
  assign er_in = p3m_is_mii(i_mode) & s2_reg[4];

  // own link clock divider; free running so the partner can sample it
  always_ff @(posedge i_ref_clk or posedge i_reset) begin
    if (i_reset) begin
      div_reg <= '0;
      lck_reg <= 1'b0;
    end else if (div_reg == DW'(LINK_HALF - 1)) begin
      div_reg <= '0;
      lck_reg <= ~lck_reg;
    end else begin
      div_reg <= div_reg + 1'b1;
    end
  end

  // clock pin directions from the mode
  always_ff @(posedge i_ref_clk or posedge i_reset) begin
    if (i_reset) begin
      txc_oe_reg <= 1'b0;
      rxc_oe_reg <= 1'b0;
      txc_o_reg <= 1'b0;
      rxc_o_reg <= 1'b0;
    end else begin
      txc_oe_reg <= p3m_dev_drv_txc(i_mode);
      rxc_oe_reg <= p3m_dev_drv_rxc(i_mode);
      // pin level from a flop; one cycle of lag is harmless, both ends resync
      txc_o_reg <= lck_reg & p3m_dev_drv_txc(i_mode);
      rxc_o_reg <= lck_reg & p3m_dev_drv_rxc(i_mode);
    end
  end

  assign lnk.dev_txc_o = txc_o_reg;
  assign lnk.dev_txc_oe = txc_oe_reg;
  assign lnk.dev_rxc_o = rxc_o_reg;
  assign lnk.dev_rxc_oe = rxc_oe_reg;

  // qualifier frames bytes, low unit first; a drop mid-byte discards it
  always_ff @(posedge i_ref_clk or posedge i_reset) begin
    if (i_reset) begin
      icnt_reg <= 2'h0;
      iacc_reg <= 8'h00;
      ierr_reg <= 1'b0;
      o_rx_valid <= 1'b0;
      o_rx_data <= 8'h00;
      o_rx_err <= 1'b0;
    end else begin
      o_rx_valid <= 1'b0;
      if (in_rise) begin
        if (s2_reg[5]) begin
          iacc_reg <= p3m_shift_in(iacc_reg, d_in, rmii);
          if (icnt_reg == (rmii ? `P3M_DIBIT_LAST : `P3M_NIB_LAST)) begin
            o_rx_valid <= 1'b1;
            o_rx_data <= p3m_shift_in(iacc_reg, d_in, rmii);
            o_rx_err <= ierr_reg | er_in;
            icnt_reg <= 2'h0;
            ierr_reg <= 1'b0;
          end else begin
            icnt_reg <= icnt_reg + 2'h1;
            ierr_reg <= ierr_reg | er_in;
          end
        end else begin
          icnt_reg <= 2'h0;
          ierr_reg <= 1'b0;
        end
      end
    end
  end

  // two-entry buffer: the link drains only at byte boundaries, so user stalls here
  assign push = i_tx_valid & o_tx_ready;
  assign pop = out_fall & (ocnt_reg == 2'h0) & (cnt_reg != '0);
  assign cnt_next = cnt_reg + CW'(push) - CW'(pop);

  always_ff @(posedge i_ref_clk or posedge i_reset) begin
    if (i_reset) begin
      wp_reg <= '0;
      rp_reg <= '0;
      cnt_reg <= '0;
      o_tx_ready <= 1'b0;
    end else begin
      cnt_reg <= cnt_next;
      o_tx_ready <= cnt_next != CW'(BUF_DEPTH);
      if (push) begin
        wp_reg <= (wp_reg == PW'(BUF_DEPTH - 1)) ? '0 : wp_reg + 1'b1;
      end
      if (pop) begin
        rp_reg <= (rp_reg == PW'(BUF_DEPTH - 1)) ? '0 : rp_reg + 1'b1;
      end
    end
  end

  // buffer storage, no reset needed on data
  always_ff @(posedge i_ref_clk) begin
    if (push) begin
      mem_reg[wp_reg] <= {i_tx_err, i_tx_data};
    end
  end

  // launch on the falling edge, partner samples on rising
  always_ff @(posedge i_ref_clk or posedge i_reset) begin
    if (i_reset) begin
      ocnt_reg <= 2'h0;
      osh_reg <= 8'h00;
      q_reg <= 1'b0;
      er_reg <= 1'b0;
      d_reg <= 4'h0;
    end else if (out_fall) begin
      if (ocnt_reg != 2'h0) begin
        d_reg <= p3m_unit(osh_reg, rmii);
        osh_reg <= p3m_shift_out(osh_reg, rmii);
        ocnt_reg <= ocnt_reg - 2'h1;
      end else if (cnt_reg != '0) begin
        q_reg <= 1'b1;
        // error pin stays low outside mii
        er_reg <= mem_reg[rp_reg][8] & p3m_is_mii(i_mode);
        // upper pair held low in rmii
        d_reg <= p3m_unit(mem_reg[rp_reg][7:0], rmii);
        osh_reg <= p3m_shift_out(mem_reg[rp_reg][7:0], rmii);
        ocnt_reg <= rmii ? `P3M_DIBIT_LAST : `P3M_NIB_LAST;
      end else begin
        q_reg <= 1'b0;
        er_reg <= 1'b0;
        d_reg <= 4'h0;
      end
    end
  end

  assign lnk.rx_qual = q_reg;
  assign lnk.rx_er = er_reg;
  assign lnk.rxd = d_reg;

endmodule : p3m_dev

// >>> p3m_partner.sv
// partner end (host mac, processor or phy) of the third-port media link
// assumes the same static mode as the device, sampled by i_ref_clk
`include "p3m_defs.svh"

module p3m_partner #(
  parameter int LINK_HALF = `P3M_LINK_HALF
) (
  // clock and reset
  input wire logic i_ref_clk,
  input wire logic i_reset,
  // static configuration, must match the device
  input wire p3m_pkg::p3m_mode_e i_mode,
  // link pins
  p3m_if.prt lnk,
  // bytes to send to the device
  input wire logic i_tx_valid,
  input wire logic [7:0] i_tx_data,
  input wire logic i_tx_err,
  output logic o_tx_ready,
  // bytes taken from the device
  output logic o_rx_valid,
  output logic [7:0] o_rx_data,
  output logic o_rx_err
);
  import p3m_pkg::*;

  localparam int DW = $clog2(LINK_HALF + 1);

  logic rmii;
  logic [7:0] s1_reg;
  logic [7:0] s2_reg;
  logic [7:0] s3_reg;
  logic out_fall;
  logic in_rise;
  logic [DW-1:0] div_reg;
  logic lck_reg;
  logic txc_oe_reg;
  logic rxc_oe_reg;
  logic txc_o_reg;
  logic rxc_o_reg;
  logic hold_reg;
  logic [8:0] hbyte_reg;
  logic [1:0] ocnt_reg;
  logic [7:0] osh_reg;
  logic q_reg;
  logic er_reg;
  logic [3:0] d_reg;
  logic [1:0] icnt_reg;
  logic [7:0] iacc_reg;
  logic ierr_reg;

  assign rmii = p3m_is_rmii(i_mode);

  // pins from the other domain: two flops, then a third for edges
  always_ff @(posedge i_ref_clk or posedge i_reset) begin
    if (i_reset) begin
      s1_reg <= 8'h00;
      s2_reg <= 8'h00;
      s3_reg <= 8'h00;
    end else begin
      s1_reg <= {lnk.txc, lnk.rxc, lnk.rx_qual, lnk.rx_er, lnk.rxd};
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
    end
  end

  // outbound uses the reference out in rmii clock mode, else the tx clock pin
  assign out_fall = (i_mode == P3M_RMII_CLK) ? (~s2_reg[6] & s3_reg[6]) : (~s2_reg[7] & s3_reg[7]);
  assign in_rise = (i_mode == P3M_RMII_NORM) ? (s2_reg[7] & ~s3_reg[7]) : (s2_reg[6] & ~s3_reg[6]);

  // own clock divider for the pins this end sources
  always_ff @(posedge i_ref_clk or posedge i_reset) begin
    if (i_reset) begin
      div_reg <= '0;
      lck_reg <= 1'b0;
    end else if (div_reg == DW'(LINK_HALF - 1)) begin
      div_reg <= '0;
      lck_reg <= ~lck_reg;
    end else begin
      div_reg <= div_reg + 1'b1;
    end
  end

  always_ff @(posedge i_ref_clk or posedge i_reset) begin
    if (i_reset) begin
      txc_oe_reg <= 1'b0;
      rxc_oe_reg <= 1'b0;
      txc_o_reg <= 1'b0;
      rxc_o_reg <= 1'b0;
    end else begin
      txc_oe_reg <= p3m_prt_drv_txc(i_mode);
      rxc_oe_reg <= p3m_prt_drv_rxc(i_mode);
      // pin level from a flop, no gate between register and pin
      txc_o_reg <= lck_reg & p3m_prt_drv_txc(i_mode);
      rxc_o_reg <= lck_reg & p3m_prt_drv_rxc(i_mode);
    end
  end

  assign lnk.prt_txc_o = txc_o_reg;
  assign lnk.prt_txc_oe = txc_oe_reg;
  assign lnk.prt_rxc_o = rxc_o_reg;
  assign lnk.prt_rxc_oe = rxc_oe_reg;

  // one-byte holding stage; ready drops until the serialiser takes it
  always_ff @(posedge i_ref_clk or posedge i_reset) begin
    if (i_reset) begin
      hold_reg <= 1'b0;
      hbyte_reg <= 9'h000;
      o_tx_ready <= 1'b0;
    end else if (i_tx_valid && o_tx_ready) begin
      hold_reg <= 1'b1;
      hbyte_reg <= {i_tx_err, i_tx_data};
      o_tx_ready <= 1'b0;
    end else if (out_fall && ocnt_reg == 2'h0 && hold_reg) begin
      hold_reg <= 1'b0;
      o_tx_ready <= 1'b1;
    end else begin
      o_tx_ready <= ~hold_reg;
    end
  end

  // enable / control high across each byte, launched on the falling edge
  always_ff @(posedge i_ref_clk or posedge i_reset) begin
    if (i_reset) begin
      ocnt_reg <= 2'h0;
      osh_reg <= 8'h00;
      q_reg <= 1'b0;
      er_reg <= 1'b0;
      d_reg <= 4'h0;
    end else if (out_fall) begin
      if (ocnt_reg != 2'h0) begin
        d_reg <= p3m_unit(osh_reg, rmii);
        osh_reg <= p3m_shift_out(osh_reg, rmii);
        ocnt_reg <= ocnt_reg - 2'h1;
      end else if (hold_reg) begin
        q_reg <= 1'b1;
        er_reg <= hbyte_reg[8] & p3m_is_mii(i_mode);
        d_reg <= p3m_unit(hbyte_reg[7:0], rmii);
        osh_reg <= p3m_shift_out(hbyte_reg[7:0], rmii);
        ocnt_reg <= rmii ? `P3M_DIBIT_LAST : `P3M_NIB_LAST;
      end else begin
        q_reg <= 1'b0;
        er_reg <= 1'b0;
        d_reg <= 4'h0;
      end
    end
  end

  assign lnk.tx_qual = q_reg;
  assign lnk.tx_er = er_reg;
  assign lnk.txd = d_reg;

  // gather units from the device into bytes
  always_ff @(posedge i_ref_clk or posedge i_reset) begin
    if (i_reset) begin
      icnt_reg <= 2'h0;
      iacc_reg <= 8'h00;
      ierr_reg <= 1'b0;
      o_rx_valid <= 1'b0;
      o_rx_data <= 8'h00;
      o_rx_err <= 1'b0;
    end else begin
      o_rx_valid <= 1'b0;
      if (in_rise) begin
        if (s2_reg[5]) begin
          iacc_reg <= p3m_shift_in(iacc_reg, s2_reg[3:0], rmii);
          if (icnt_reg == (rmii ? `P3M_DIBIT_LAST : `P3M_NIB_LAST)) begin
            o_rx_valid <= 1'b1;
            o_rx_data <= p3m_shift_in(iacc_reg, s2_reg[3:0], rmii);
            o_rx_err <= ierr_reg | s2_reg[4];
            icnt_reg <= 2'h0;
            ierr_reg <= 1'b0;
          end else begin
            icnt_reg <= icnt_reg + 2'h1;
            ierr_reg <= ierr_reg | s2_reg[4];
          end
        end else begin
          icnt_reg <= 2'h0;
          ierr_reg <= 1'b0;
        end
      end
    end
  end

endmodule : p3m_partner

// >>> p3m_link_sva.sv
// checker for the third-port media link, watching the joining interface
// assumes one static mode per reset and divider-made link clocks
module p3m_link_sva
  import p3m_pkg::*;
#(
  parameter int LINK_HALF = 8
) (
  // clock and reset
  input wire logic i_ref_clk,
  input wire logic i_reset,
  input wire p3m_mode_e i_mode,
  // link pins
  input wire logic dev_txc_oe,
  input wire logic prt_txc_oe,
  input wire logic dev_rxc_oe,
  input wire logic prt_rxc_oe,
  input wire logic rxc,
  input wire logic rx_er,
  input wire logic [3:0] rxd
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (i_reset);
  logic mii_m;
  logic rmii_m;
  logic seen_reg;
  logic [7:0] gap_reg;
  // mode groups spelled out, not shared with the design helpers
  assign mii_m = (i_mode == P3M_MII_PHY) || (i_mode == P3M_MII_MAC);
  assign rmii_m = (i_mode == P3M_RMII_NORM) || (i_mode == P3M_RMII_CLK);
  // cycles between rises; first rise after reset has no reference
  always_ff @(posedge i_ref_clk or posedge i_reset) begin
    if (i_reset) begin
      gap_reg <= 8'h00;
      seen_reg <= 1'b0;
    end else begin
      gap_reg <= $rose(rxc) ? 8'h01 : gap_reg + 8'h01;
      seen_reg <= seen_reg | $rose(rxc);
    end
  end
  sequence s_out_of_reset;
    !$past(i_reset);
  endsequence
  sequence s_rxc_rise;
    $rose(rxc) && seen_reg;
  endsequence
  chk_dev_txc_role: assert property (s_out_of_reset |-> dev_txc_oe == (i_mode == P3M_MII_PHY))
    else $error("device transmit clock drive wrong for mode");
  chk_prt_txc_role: assert property (s_out_of_reset |-> prt_txc_oe ==
    (i_mode inside {P3M_MII_MAC, P3M_RMII_NORM, P3M_RGMII}))
    else $error("partner transmit clock drive wrong for mode");
  chk_dev_rxc_role: assert property (s_out_of_reset |-> dev_rxc_oe ==
    (i_mode inside {P3M_MII_PHY, P3M_RMII_CLK, P3M_RGMII}))
    else $error("device receive clock drive wrong for mode");
  chk_prt_rxc_role: assert property (s_out_of_reset |-> prt_rxc_oe == (i_mode == P3M_MII_MAC))
    else $error("partner receive clock drive wrong for mode");
  chk_one_driver: assert property (!(dev_txc_oe && prt_txc_oe) && !(dev_rxc_oe && prt_rxc_oe))
    else $error("two ends drive one clock pin");
  chk_rx_err_idle: assert property (!mii_m |-> !rx_er)
    else $error("receive error driven outside mii");
  chk_rxd_high_idle: assert property (rmii_m |-> rxd[3:2] == 2'h0)
    else $error("receive data high bits driven in rmii");
  chk_rxc_period: assert property (s_rxc_rise |-> gap_reg == 8'(2 * LINK_HALF))
    else $error("receive clock period wrong");
endmodule : p3m_link_sva

// >>> testbench.sv
// bench: both ends joined per mode, plus a lone device fed by a bench-made rmii clock
// assumes a 100 MHz system clock and the mode held static while out of reset
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  import p3m_pkg::*;
  logic ref_clk = 1'b0;
  logic reset = 1'b1;
  p3m_mode_e mode = P3M_MII_PHY;
  logic d_tx_valid = 1'b0, d_tx_err = 1'b0, d_tx_ready, d_rx_valid, d_rx_err;
  logic p_tx_valid = 1'b0, p_tx_err = 1'b0, p_tx_ready, p_rx_valid, p_rx_err, e_rx_valid, e_rx_err;
  logic [7:0] d_tx_data = 8'h00, p_tx_data = 8'h00, d_rx_data, p_rx_data, e_rx_data;
  logic [8:0] q_dev[$], q_prt[$], q_e[$];
  logic [8:0] dv[4] = '{9'h1A5, 9'h03C, 9'h0FF, 9'h15A};
  logic [8:0] pv[2] = '{9'h1C3, 9'h069};
  logic [3:0] exp_oe[5] = '{4'hA, 4'h5, 4'h4, 4'h2, 4'h6};
  logic full_seen;
  int num_errors = 0, tests_run = 0, cycles = 0;
  p3m_if lnk();
  p3m_if lnk2();

  p3m_dev p3m_dev_i (.i_ref_clk(ref_clk), .i_reset(reset), .i_mode(mode),
    .lnk(lnk.dev), .o_rx_valid(d_rx_valid), .o_rx_data(d_rx_data), .o_rx_err(d_rx_err),
    .i_tx_valid(d_tx_valid), .i_tx_data(d_tx_data), .i_tx_err(d_tx_err), .o_tx_ready(d_tx_ready));
  p3m_partner p3m_partner_i (.i_ref_clk(ref_clk), .i_reset(reset), .i_mode(mode),
    .lnk(lnk.prt), .i_tx_valid(p_tx_valid), .i_tx_data(p_tx_data), .i_tx_err(p_tx_err),
    .o_tx_ready(p_tx_ready), .o_rx_valid(p_rx_valid), .o_rx_data(p_rx_data), .o_rx_err(p_rx_err));
  // lone device, its partner side driven by the bench
  p3m_dev p3m_dev_i2 (.i_ref_clk(ref_clk), .i_reset(reset),
    .i_mode(P3M_RMII_NORM), .lnk(lnk2.dev), .o_rx_valid(e_rx_valid), .o_rx_data(e_rx_data),
    .o_rx_err(e_rx_err), .i_tx_valid(1'b0), .i_tx_data(8'h00), .i_tx_err(1'b0), .o_tx_ready());
  p3m_link_sva p3m_link_sva_i (.i_ref_clk(ref_clk), .i_reset(reset), .i_mode(mode),
    .dev_txc_oe(lnk.dev_txc_oe), .prt_txc_oe(lnk.prt_txc_oe), .dev_rxc_oe(lnk.dev_rxc_oe),
    .prt_rxc_oe(lnk.prt_rxc_oe), .rxc(lnk.rxc), .rx_er(lnk.rx_er), .rxd(lnk.rxd));

  initial begin
    forever #5 ref_clk = ~ref_clk;
  end
  // pulses last one cycle; the falling edge sees them settled
  always @(negedge ref_clk) begin
    if (d_rx_valid === 1'b1) q_dev.push_back({d_rx_err, d_rx_data});
    if (p_rx_valid === 1'b1) q_prt.push_back({p_rx_err, p_rx_data});
    if (e_rx_valid === 1'b1) q_e.push_back({e_rx_err, e_rx_data});
  end
  // hang guard, well above the under two thousand cycles the run needs
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 30000) begin
      num_errors++;
      end_of_test();
    end
  end

  task check(input logic [8:0] got, input logic [8:0] exp);
    tests_run++;
    if (got !== exp) begin
      num_errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check

  // request at a falling edge, held until a rising edge sees ready
  task send(input bit from_prt, input logic [8:0] v);
    if (from_prt) begin
      p_tx_valid = 1'b1;
      p_tx_data = v[7:0];
      p_tx_err = v[8];
    end else begin
      d_tx_valid = 1'b1;
      d_tx_data = v[7:0];
      d_tx_err = v[8];
    end
    while ((from_prt ? p_tx_ready : d_tx_ready) !== 1'b1) begin
      if (!from_prt) full_seen = 1'b1;
      @(negedge ref_clk);
    end
    @(negedge ref_clk);
  endtask : send

  // one rmii byte at 160 ns, high bits and error pin junk
  task rmii_byte(input logic [7:0] b);
    for (int i = 0; i < 4; i++) begin
      lnk2.prt_txc_o = 1'b0;
      lnk2.tx_qual = 1'b1;
      lnk2.tx_er = 1'b1;
      lnk2.txd = {2'h3, b[2*i +: 2]};
      #80 lnk2.prt_txc_o = 1'b1;
      #80;
    end
  endtask : rmii_byte

  task end_of_test();
    $display("tests_run %0d num_errors %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : end_of_test

  initial begin
    lnk2.prt_txc_oe = 1'b1;
    lnk2.prt_txc_o = 1'b0;
    lnk2.prt_rxc_oe = 1'b0;
    lnk2.prt_rxc_o = 1'b0;
    lnk2.tx_qual = 1'b0;
    lnk2.tx_er = 1'b0;
    lnk2.txd = 4'h0;
    for (int m = 0; m < 5; m++) begin
      @(negedge ref_clk);
      reset = 1'b1;
      mode = p3m_mode_e'(m);
      full_seen = 1'b0;
      repeat (20) @(negedge ref_clk);
      reset = 1'b0;
      repeat (2) @(negedge ref_clk);
      check({5'h00, lnk.dev_txc_oe, lnk.prt_txc_oe, lnk.dev_rxc_oe, lnk.prt_rxc_oe}, {5'h00, exp_oe[m]});
      // four bytes back to back overrun the two-entry buffer
      foreach (dv[i]) send(1'b0, dv[i]);
      d_tx_valid = 1'b0;
      foreach (pv[i]) send(1'b1, pv[i]);
      p_tx_valid = 1'b0;
      wait (q_prt.size() == 4 && q_dev.size() == 2);
      check({8'h00, full_seen}, 9'h001);
      // error bit crosses only in mii
      foreach (dv[i]) check(q_prt[i], {dv[i][8] & (m < 2), dv[i][7:0]});
      foreach (pv[i]) check(q_dev[i], {pv[i][8] & (m < 2), pv[i][7:0]});
      q_prt.delete();
      q_dev.delete();
    end
    @(negedge ref_clk);
    rmii_byte(8'h96);
    rmii_byte(8'h3C);
    // lines go idle only after the last byte, so no pin toggles in zero time
    lnk2.prt_txc_o = 1'b0;
    lnk2.tx_qual = 1'b0;
    lnk2.tx_er = 1'b0;
    lnk2.txd = 4'h0;
    wait (q_e.size() == 2);
    check(q_e[0], 9'h096);
    check(q_e[1], 9'h03C);
    end_of_test();
  end
endmodule : testbench
